//--- rtl/osir_sensor_top.sv
// optical sensor readout: i2c registers, sticky status, measurement control
//
// Contract
// [RQ1] event sets status bit until written one
// [RQ2] interrupt pin low while any status set
// [RQ3] writing zero leaves status bit alone
// [RQ4] delay field at bit 7 down, default zero
// [RQ5] host writes one to modulator timing register
// [RQ6] receiver idles in standby without measurement
// [RQ7] emitter sink off in standby always
// [RQ8] host addresses register with write, no data
// [RQ9] read returns the addressed register
// [RQ10] stop-start or repeated start both accepted
// [RQ11] pointer increments after every byte read
// [RQ12] sixteen-bit results high byte at lower address
// [RQ13] standard ambient cycle fills 100 ms frame
// [RQ14] one ambient conversion takes about 300 us
// [RQ15] result averages configured count, up to 128
// [RQ16] standard result only at frame end
// [RQ17] continuous mode runs conversions back to back
// [RQ18] status holds four separate event flags
`timescale 1ns/1ns
`default_nettype none
module osir_sensor_top #(
	parameter int FRAME_CYC = osir_pkg::ALS_FRAME_CYC,  // frame length
	parameter int CONV_CYC  = osir_pkg::CONV_CYC        // conversion length
) (
	input  wire logic                        clk_sys,      // 250 MHz clock
	input  wire logic                        rst_b,        // async reset
	input  wire logic                        scl_i,        // i2c clock pin
	input  wire logic                        sda_i,        // i2c data in
	output logic                             sda_o,        // i2c data out
	output logic                             sda_oe,       // pull sda low
	output logic                             int_o,        // irq pin out
	output logic                             int_oe,       // pull irq low
	input  wire logic [osir_pkg::DATA_W-1:0] als_adc_data, // ambient adc
	input  wire logic [osir_pkg::DATA_W-1:0] bio_adc_data, // bio adc
	output logic                             led_sink_en,  // emitter sink
	output logic [7:0]                       led_current,  // sink level
	output logic [7:0]                       mod_timing,   // modulator set
	output logic                             rx_standby,   // receiver idle
	output logic                             als_sampling  // ambient converting
);
	import osir_pkg::*;

	localparam logic [CONV_CW-1:0] CONV_LAST = CONV_CW'(CONV_CYC - 1);

	// ******************************
	// reset release and pin sampling
	// ******************************
	logic [1:0] rst_sh;  // release chain
	logic [2:0] scl_s;   // scl sampler, bit 0 first
	logic [2:0] sda_s;   // sda sampler, bit 0 first
	logic       scl_f;   // accepted scl level
	logic       sda_f;   // accepted sda level
	wire        rst_n = rst_sh[1];

	// a level counts once the second and third stage agree
	wire next_scl = (scl_s[1] == scl_s[2]) ? scl_s[2] : scl_f;
	wire next_sda = (sda_s[1] == sda_s[2]) ? sda_s[2] : sda_f;
	wire scl_rise = next_scl && !scl_f;
	wire scl_fall = !next_scl && scl_f;
	// start or stop only while scl is high; restart allowed anywhere
	wire bus_start = scl_f && next_scl && sda_f && !next_sda;  // [RQ10]
	wire bus_stop  = scl_f && next_scl && !sda_f && next_sda;  // [RQ10]

	// reset enters asynchronously, releases on the clock
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			rst_sh <= 2'h0;
		end else begin
			rst_sh <= {rst_sh[0], 1'b1};
		end
	end

	// three-stage samplers; idle bus reads high
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			scl_s <= 3'h7;
			sda_s <= 3'h7;
			scl_f <= 1'b1;
			sda_f <= 1'b1;
		end else begin
			scl_s <= {scl_s[1:0], scl_i};
			sda_s <= {sda_s[1:0], sda_i};
			scl_f <= next_scl;
			sda_f <= next_sda;
		end
	end

	// ******************************
	// i2c slave
	// ******************************
	osir_i2c_st_t st;          // bus state
	logic [3:0]   bit_cnt;     // bits of the current byte
	logic [7:0]   rx_sh;       // received byte
	logic [7:0]   tx_sh;       // byte being sent
	logic         rw;          // read bit of the address byte
	logic         first_byte;  // next written byte is the pointer
	logic [7:0]   ptr;         // register pointer
	logic         nack;        // master refused more data

	logic [7:0] cmd_q;         // unused bits of the request register
	logic [7:0] als_cfg;       // ambient configuration
	logic [15:0] thr_lo;       // low limit
	logic [15:0] thr_hi;       // high limit
	logic [15:0] bio_result;   // last bio result
	logic [3:0] irq_status;    // sticky event flags
	logic [CONV_CW-1:0] bio_cnt;  // bio conversion timer
	wire        als_busy;
	wire        als_done;
	wire [15:0] als_result;

	wire byte_end = scl_fall && bit_cnt == 4'h8;
	wire addr_hit = rx_sh[7:1] == I2C_DEV_ADDR;
	wire wr_stb   = byte_end && st == I_WR && !first_byte;
	wire [7:0] wdata = rx_sh;

	// register read mux; results sit high byte first
	// a plain net follows every register, not only pointer changes
	wire [7:0] rd_byte =  // [RQ9]
		(ptr == REG_CMD)      ? {3'h0, als_busy, led_sink_en, 3'h0} :
		(ptr == REG_LED)      ? led_current :
		(ptr == REG_ALS_CFG)  ? als_cfg :
		(ptr == REG_ALS_HI)   ? als_result[15:8] :  // [RQ12]
		(ptr == REG_ALS_LO)   ? als_result[7:0] :   // [RQ12]
		(ptr == REG_BIO_HI)   ? bio_result[15:8] :  // [RQ12]
		(ptr == REG_BIO_LO)   ? bio_result[7:0] :   // [RQ12]
		(ptr == REG_TLO_HI)   ? thr_lo[15:8] :
		(ptr == REG_TLO_LO)   ? thr_lo[7:0] :
		(ptr == REG_THI_HI)   ? thr_hi[15:8] :
		(ptr == REG_THI_LO)   ? thr_hi[7:0] :
		(ptr == REG_IRQ_STAT) ? {4'h0, irq_status} :
		(ptr == REG_MOD_TIME) ? mod_timing :
		8'h00;  // reserved and unmapped

	// bus state machine; data changes only while scl is low
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			st         <= I_IDLE;
			bit_cnt    <= 4'h0;
			rx_sh      <= 8'h00;
			tx_sh      <= 8'h00;
			rw         <= 1'b0;
			first_byte <= 1'b0;
			ptr        <= 8'h00;
			nack       <= 1'b0;
			sda_oe     <= 1'b0;
			sda_o      <= 1'b0;
		end else if (bus_start) begin
			st      <= I_ADDR;  // [RQ10]
			bit_cnt <= 4'h0;
			sda_oe  <= 1'b0;
		end else if (bus_stop) begin
			st     <= I_IDLE;   // pointer survives for a later read
			sda_oe <= 1'b0;
		end else if (scl_rise) begin
			bit_cnt <= bit_cnt + 4'h1;
			rx_sh   <= {rx_sh[6:0], sda_f};
			nack    <= sda_f;
		end else if (scl_fall) begin
			case (st)
				I_ADDR: begin
					if (bit_cnt == 4'h8) begin
						st     <= addr_hit ? I_AACK : I_IDLE;
						sda_oe <= addr_hit;
						rw     <= rx_sh[0];
					end
				end
				I_AACK: begin
					bit_cnt <= 4'h0;
					if (rw) begin
						st     <= I_RD;
						sda_oe <= !rd_byte[7];  // [RQ9]
						tx_sh  <= {rd_byte[6:0], 1'b0};
					end else begin
						st         <= I_WR;
						sda_oe     <= 1'b0;
						first_byte <= 1'b1;
					end
				end
				I_WR: begin
					if (bit_cnt == 4'h8) begin
						if (first_byte) begin
							ptr <= rx_sh;  // [RQ8]
						end else begin
							ptr <= ptr + 8'h01;
						end
						st     <= I_WACK;
						sda_oe <= 1'b1;
					end
				end
				I_WACK: begin
					st         <= I_WR;
					bit_cnt    <= 4'h0;
					sda_oe     <= 1'b0;
					first_byte <= 1'b0;
				end
				I_RD: begin
					if (bit_cnt == 4'h8) begin
						st     <= I_RACK;
						sda_oe <= 1'b0;
						ptr    <= ptr + 8'h01;  // [RQ11]
					end else begin
						sda_oe <= !tx_sh[7];
						tx_sh  <= {tx_sh[6:0], 1'b0};
					end
				end
				I_RACK: begin
					bit_cnt <= 4'h0;
					st      <= nack ? I_IDLE : I_RD;
					sda_oe  <= !nack && !rd_byte[7];  // [RQ11]
					tx_sh   <= {rd_byte[6:0], 1'b0};
				end
				default: begin
					st <= I_IDLE;
				end
			endcase
		end
	end

	// ******************************
	// configuration registers
	// ******************************
	wire wr_cmd  = wr_stb && ptr == REG_CMD;
	wire als_req = wr_cmd && wdata[CMD_ALS_REQ_BIT];
	wire bio_req = wr_cmd && wdata[CMD_BIO_REQ_BIT];

	// plain read-write registers
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cmd_q       <= 8'h00;
			led_current <= LED_RST;
			als_cfg     <= ALS_CFG_RST;
			thr_lo      <= 16'h0000;
			thr_hi      <= 16'h0000;
			mod_timing  <= MOD_TIME_RST;  // [RQ4] [RQ5]
		end else if (wr_stb) begin
			case (ptr)
				REG_CMD:      cmd_q         <= wdata;
				REG_LED:      led_current   <= wdata;
				REG_ALS_CFG:  als_cfg       <= wdata;
				REG_TLO_HI:   thr_lo[15:8]  <= wdata;
				REG_TLO_LO:   thr_lo[7:0]   <= wdata;
				REG_THI_HI:   thr_hi[15:8]  <= wdata;
				REG_THI_LO:   thr_hi[7:0]   <= wdata;
				REG_MOD_TIME: mod_timing    <= wdata;  // [RQ4]
				default:      cmd_q         <= cmd_q;  // read-only or reserved
			endcase
		end
	end

	// ******************************
	// measurements
	// ******************************
	osir_als_seq #(
		.FRAME_CYC (FRAME_CYC),
		.CONV_CYC  (CONV_CYC)
	) u_als (
		.clk_sys  (clk_sys),
		.rst_n    (rst_n),
		.start    (als_req),
		.cont     (als_cfg[CFG_CONT_BIT]),       // [RQ13] [RQ17]
		.avg_code (als_cfg[CFG_AVG_LSB +: 3]),   // [RQ15]
		.adc_data (als_adc_data),
		.sampling (als_sampling),
		.busy     (als_busy),
		.done     (als_done),
		.result   (als_result)
	);

	wire bio_end = led_sink_en && bio_cnt == CONV_LAST;
	logic bio_done;  // one-cycle bio ready event

	// the sink only runs during a bio conversion, whatever led_current says
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			led_sink_en <= 1'b0;
			bio_cnt     <= 17'h00000;
			bio_result  <= 16'h0000;
			bio_done    <= 1'b0;
			rx_standby  <= 1'b1;
		end else begin
			bio_done   <= bio_end;
			rx_standby <= !(led_sink_en || als_busy || bio_req
				|| als_req);  // [RQ6]
			if (bio_req && !led_sink_en) begin
				led_sink_en <= 1'b1;  // [RQ7]
				bio_cnt     <= 17'h00000;
			end else if (bio_end) begin
				led_sink_en <= 1'b0;  // [RQ7]
				bio_result  <= bio_adc_data;
			end else if (led_sink_en) begin
				bio_cnt <= bio_cnt + 17'h00001;
			end
		end
	end

	// ******************************
	// interrupt status
	// ******************************
	wire below = als_done && als_result < thr_lo;
	wire above = als_done && als_result > thr_hi;
	wire [3:0] st_set = {bio_done, als_done, below, above};  // [RQ18]
	wire [3:0] st_clr = (wr_stb && ptr == REG_IRQ_STAT) ? wdata[3:0]
		: 4'h0;
	// a new event wins over a clear in the same cycle
	wire [3:0] next_status = (irq_status & ~st_clr) | st_set;  // [RQ1] [RQ3]

	// status and open-drain pin; pin follows the stored flags
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			irq_status <= 4'h0;
			int_oe     <= 1'b0;
			int_o      <= 1'b0;
		end else begin
			irq_status <= next_status;
			int_oe     <= |next_status;  // [RQ2]
		end
	end

	// ******************************
	// checks
	// ******************************
	a_irq_pin_level: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RQ2]
		int_oe == (|irq_status))
		else $error("irq pin does not follow status");
	a_status_hold: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RQ3]
		1'b1 |=> ((($past(irq_status) & ~$past(st_clr)) & ~irq_status)
			== 4'h0))
		else $error("status bit dropped without a one written");
	a_status_set: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RQ1]
		(|st_set) |=> ((irq_status & $past(st_set)) == $past(st_set)))
		else $error("event did not set its status bit");
	a_status_clear: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RQ1]
		(|st_clr && st_set == 4'h0) |=> ((irq_status & $past(st_clr))
			== 4'h0))
		else $error("written one did not clear status");
	a_sink_request: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RQ7]
		(!led_sink_en && !bio_req) |=> !led_sink_en)
		else $error("emitter sink active without request");
	a_ptr_step: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RQ11]
		(!bus_start && !bus_stop && st == I_RD && byte_end)
			|=> ptr == $past(ptr) + 8'h01)
		else $error("pointer not advanced after read byte");
	a_read_first: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RQ9]
		(!bus_start && !bus_stop && scl_fall && st == I_AACK && rw)
			|=> sda_oe == !$past(rd_byte[7]))
		else $error("read does not start with addressed register");

endmodule // osir_sensor_top
`default_nettype wire

//--- rtl/osir_pkg.sv
// constants and types shared by the optical sensor readout block
package osir_pkg;

	// ******************************
	// bus address and register map
	// ******************************
	localparam logic [6:0] I2C_DEV_ADDR = 7'h13;  // 7-bit slave address
	localparam logic [7:0] REG_CMD      = 8'h80;  // measurement requests
	localparam logic [7:0] REG_LED      = 8'h83;  // emitter current setting
	localparam logic [7:0] REG_ALS_CFG  = 8'h84;  // ambient configuration
	localparam logic [7:0] REG_ALS_HI   = 8'h85;  // ambient result high
	localparam logic [7:0] REG_ALS_LO   = 8'h86;  // ambient result low
	localparam logic [7:0] REG_BIO_HI   = 8'h87;  // bio result high
	localparam logic [7:0] REG_BIO_LO   = 8'h88;  // bio result low
	localparam logic [7:0] REG_TLO_HI   = 8'h8A;  // low limit high byte
	localparam logic [7:0] REG_TLO_LO   = 8'h8B;  // low limit low byte
	localparam logic [7:0] REG_THI_HI   = 8'h8C;  // high limit high byte
	localparam logic [7:0] REG_THI_LO   = 8'h8D;  // high limit low byte
	localparam logic [7:0] REG_IRQ_STAT = 8'h8E;  // sticky status
	localparam logic [7:0] REG_MOD_TIME = 8'h8F;  // modulator timing
	localparam logic [7:0] REG_AMB_IR   = 8'h90;  // reserved, reads zero

	// ******************************
	// field positions
	// ******************************
	localparam int CMD_BIO_REQ_BIT = 3;  // start one bio measurement
	localparam int CMD_ALS_REQ_BIT = 4;  // start one ambient measurement
	localparam int CFG_CONT_BIT    = 7;  // continuous conversion
	localparam int CFG_AVG_LSB     = 0;  // averaging code, 2**code
	localparam int ST_HIGH_BIT     = 0;  // above_limit_flag
	localparam int ST_LOW_BIT      = 1;  // below_limit_flag
	localparam int ST_ALS_BIT      = 2;  // ambient ready
	localparam int ST_BIO_BIT      = 3;  // bio_result_ready_flag
	localparam int MOD_DELAY_LSB   = 5;  // delay field, bits 7:5
	localparam int MOD_RATE_LSB    = 3;  // sensing_modulation_rate
	localparam int MOD_DEAD_LSB    = 0;  // dead-time field, bits 2:0
	localparam int DATA_W          = 16; // result width

	// ******************************
	// reset values
	// ******************************
	localparam logic [7:0] MOD_TIME_RST = 8'h01;  // delay 0, dead 1
	localparam logic [7:0] LED_RST      = 8'h02;
	localparam logic [7:0] ALS_CFG_RST  = 8'h01;

	// ******************************
	// timing
	// ******************************
	localparam int CLK_MHZ       = 250;
	localparam int ALS_FRAME_MS  = 100;
	localparam int CONV_US       = 300;
	localparam int ALS_FRAME_CYC = ALS_FRAME_MS * 1000 * CLK_MHZ;
	localparam int CONV_CYC      = CONV_US * CLK_MHZ;
	localparam int FRAME_CW      = 25;  // counter width for the frame
	localparam int CONV_CW       = 17;  // counter width for one conversion

	typedef enum logic [2:0] {
		I_IDLE, I_ADDR, I_AACK, I_WR, I_WACK, I_RD, I_RACK
	} osir_i2c_st_t;

endpackage

//--- rtl/osir_als_seq.sv
// ambient light sequencer: frame timing, conversions and averaging
`timescale 1ns/1ns
`default_nettype none
module osir_als_seq #(
	parameter int FRAME_CYC = osir_pkg::ALS_FRAME_CYC,  // cycles per frame
	parameter int CONV_CYC  = osir_pkg::CONV_CYC        // cycles per sample
) (
	input  wire logic                        clk_sys,   // system clock
	input  wire logic                        rst_n,     // synced reset
	input  wire logic                        start,     // one-cycle request
	input  wire logic                        cont,      // continuous mode
	input  wire logic [2:0]                  avg_code,  // 2**code samples
	input  wire logic [osir_pkg::DATA_W-1:0] adc_data,  // converter output
	output logic                             sampling,  // conversion running
	output logic                             busy,      // cycle in progress
	output logic                             done,      // result pulse
	output logic [osir_pkg::DATA_W-1:0]      result     // averaged result
);
	import osir_pkg::*;

	// ******************************
	// counters and decode
	// ******************************
	localparam logic [FRAME_CW-1:0] FRAME_LAST = FRAME_CW'(FRAME_CYC - 1);
	localparam logic [FRAME_CW-1:0] FRAME_LEN  = FRAME_CW'(FRAME_CYC);
	localparam logic [CONV_CW-1:0]  CONV_LAST  = CONV_CW'(CONV_CYC - 1);

	logic [FRAME_CW-1:0] frame_cnt;  // position in the frame
	logic [FRAME_CW-1:0] slot_cnt;   // position in the sample slot
	logic [CONV_CW-1:0]  conv_cnt;   // position in one conversion
	logic [7:0]          n_cnt;      // conversions summed so far
	logic [22:0]         acc;        // running sum, 16 + 7 bits
	logic [2:0]          avg_q;      // averaging code held per cycle
	logic                cont_q;     // mode held per cycle

	// standard mode spreads the samples evenly over the frame; the slot is
	// the frame divided down, so the last sample still ends inside it
	wire [FRAME_CW-1:0] slot_last = (FRAME_LEN >> avg_q) - 25'h0000001;
	wire [7:0]          total     = 8'h01 << avg_q;
	wire                conv_end  = sampling && conv_cnt == CONV_LAST; // [RQ14]
	wire                last_conv = conv_end && (n_cnt + 8'h01 == total);
	wire [22:0]         sum_now   = acc + {7'h00, adc_data};
	// continuous mode ends on its last sample, standard mode on frame end
	wire finish = busy && (cont_q ? last_conv
		: frame_cnt == FRAME_LAST);  // [RQ13] [RQ16]
	wire next_slot = busy && !cont_q && !sampling
		&& slot_cnt == slot_last && n_cnt != total;

	// ******************************
	// sequencing
	// ******************************
	// a request while busy is dropped; the cycle already running wins
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			busy      <= 1'b0;
			sampling  <= 1'b0;
			done      <= 1'b0;
			result    <= 16'h0000;
			frame_cnt <= 25'h0000000;
			slot_cnt  <= 25'h0000000;
			conv_cnt  <= 17'h00000;
			n_cnt     <= 8'h00;
			acc       <= 23'h000000;
			avg_q     <= 3'h0;
			cont_q    <= 1'b0;
		end else begin
			done <= finish;
			if (start && !busy) begin
				busy      <= 1'b1;
				sampling  <= 1'b1;
				frame_cnt <= 25'h0000000;
				slot_cnt  <= 25'h0000000;
				conv_cnt  <= 17'h00000;
				n_cnt     <= 8'h00;
				acc       <= 23'h000000;
				avg_q     <= avg_code;
				cont_q    <= cont;
			end else if (busy) begin
				frame_cnt <= frame_cnt + 25'h0000001;
				slot_cnt  <= (slot_cnt == slot_last) ? 25'h0000000
					: slot_cnt + 25'h0000001;
				conv_cnt  <= (conv_end || !sampling) ? 17'h00000
					: conv_cnt + 17'h00001;
				if (conv_end) begin
					acc   <= sum_now;  // [RQ15]
					n_cnt <= n_cnt + 8'h01;
					// back to back in continuous mode, no idle gap
					sampling <= cont_q && !last_conv;  // [RQ17]
				end else if (next_slot) begin
					sampling <= 1'b1;
				end
				if (finish) begin
					busy     <= 1'b0;
					sampling <= 1'b0;
					result   <= cont_q ? 16'(sum_now >> avg_q)
						: 16'(acc >> avg_q);  // [RQ15]
				end
			end
		end
	end

	// ******************************
	// checks
	// ******************************
	a_frame_result: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RQ16]
		(done && !cont_q) |-> $past(frame_cnt) == FRAME_LAST)
		else $error("standard result not at frame end");
	a_cont_gapless: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RQ17]
		(busy && cont_q && !$rose(busy)) |-> sampling)
		else $error("gap between continuous conversions");
	a_avg_count: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RQ15]
		done |-> n_cnt == total)
		else $error("result not over configured sample count");

endmodule // osir_als_seq
`default_nettype wire

//--- testbench/osir_i2c_host.sv
// i2c bus master model standing in for the host controller
`timescale 1ns/1ns
`default_nettype none
module osir_i2c_host (
	input  wire logic clk_sys,  // bench clock
	input  wire logic dev_pull, // device pulls sda low
	output logic      scl_i,    // scl level at the device
	output logic      sda_i     // sda level, pulled up
);
	logic scl_low  = 1'b0; // host holds scl low
	logic sda_low  = 1'b0; // host holds sda low
	logic seen;            // sda level just before the last step
	logic nak_seen = 1'b0; // some written byte went unacknowledged
	// pull-ups: a released line reads high, any pull-down wins
	assign scl_i = ~scl_low;
	assign sda_i = ~(sda_low | dev_pull);
	task automatic gap(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	// ten cycles a step keeps scl phases and sda hold well past the minimum
	task automatic step(input logic d, input logic c);
		gap(10);
		seen = sda_i;
		sda_low = d;
		scl_low = c;
	endtask
	// start or repeated start: sda falls while scl is high
	task automatic start();
		step(1'b0, 1'b1);
		step(1'b0, 1'b0);
		step(1'b1, 1'b0);
		step(1'b1, 1'b1);
	endtask
	// stop: sda rises while scl is high
	task automatic stop();
		step(1'b1, 1'b1);
		step(1'b1, 1'b0);
		step(1'b0, 1'b0);
	endtask
	// data set mid-low, sampled at the end of the high phase
	task automatic bit_io(input logic b, output logic r);
		step(~b, 1'b1);
		step(~b, 1'b0);
		step(~b, 1'b1);
		r = seen;
	endtask
	task automatic xfer(input logic [7:0] d, input logic m,
		output logic [7:0] q, output logic k);
		for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
		bit_io(m, k);
	endtask
	// write n bytes, most significant first, at pointer, pointer+1 and onward
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input int n);
		logic [7:0] q;
		logic       k;
		start();
		xfer(8'h26, 1'b1, q, k);
		nak_seen |= k;
		xfer(a, 1'b1, q, k);
		nak_seen |= k;
		for (int i = 0; i < n; i++) begin
			xfer(d[8*(n-1-i) +: 8], 1'b1, q, k);
			nak_seen |= k;
		end
		stop();
	endtask
	// address with a write holding no data, then read n bytes
	task automatic rd(input logic [7:0] a, input logic rs, input int n,
		output logic [15:0] v);
		logic [7:0] q;
		logic       k;
		v = 16'h0000;
		start();
		xfer(8'h26, 1'b1, q, k);
		xfer(a, 1'b1, q, k);
		if (!rs) stop(); // stop then start, else repeated start
		start();
		xfer(8'h27, 1'b1, q, k);
		for (int i = 0; i < n; i++) begin
			xfer(8'hFF, i == n - 1, q, k); // nack on the last byte
			v = {v[7:0], q};
		end
		stop();
	endtask
endmodule // osir_i2c_host
`default_nettype wire

//--- testbench/tb_optical_sensor_irq_and_readout.sv
// self-checking bench for the optical sensor readout block
`timescale 1ns/1ns
`default_nettype none
module tb_optical_sensor_irq_and_readout;
	import osir_pkg::*;
	localparam int FRAME = 4000; // short frame, still room for 128 samples
	localparam int CONV  = 20;   // short conversion
	logic        clk_sys = 1'b0; // bench clock
	logic        rst_b   = 1'b0; // reset, active low
	wire logic   scl_i, sda_i;   // bus levels from the host model
	logic        sda_oe, int_oe, led_sink_en, rx_standby, als_sampling;
	logic        sda_o, int_o;   // open-drain data levels, always low
	int          samp_cyc = 0;   // cycle within the current conversion
	logic [15:0] als_adc_data = 16'h0000; // ambient converter value
	logic [15:0] bio_adc_data = 16'h0000; // bio converter value
	logic [7:0]  led_current, mod_timing; // register images at the pins
	logic [15:0] seed = 16'h0051; // random state
	logic [15:0] v;               // value read back
	int          failures = 0, num_checks = 0;
	int          sum = 0, nconv = 0, run_cyc = 0, sink_cyc = 0, bad_sink = 0;
	osir_sensor_top #(.FRAME_CYC(FRAME), .CONV_CYC(CONV)) dut_u (
		.clk_sys(clk_sys), .rst_b(rst_b), .scl_i(scl_i), .sda_i(sda_i),
		.sda_o(sda_o), .sda_oe(sda_oe), .int_o(int_o), .int_oe(int_oe),
		.als_adc_data(als_adc_data), .bio_adc_data(bio_adc_data),
		.led_sink_en(led_sink_en), .led_current(led_current),
		.mod_timing(mod_timing), .rx_standby(rx_standby),
		.als_sampling(als_sampling));
	osir_i2c_host host_u (.clk_sys(clk_sys), .dev_pull(sda_oe),
		.scl_i(scl_i), .sda_i(sda_i));
	always #2 clk_sys = ~clk_sys;
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	// ambient flags expected with the low limit at top, high limit at zero
	function automatic logic [15:0] als_stat(input logic [15:0] res);
		return {12'h000, 2'b01, res < 16'hFFFF, res > 16'h0000};
	endfunction
	// new ambient sample at each conversion start; time the run to irq
	always @(posedge clk_sys) begin
		samp_cyc <= (als_sampling && samp_cyc != CONV - 1) ? samp_cyc + 1 : 0;
		sink_cyc <= sink_cyc + int'(led_sink_en);
		bad_sink <= bad_sink + int'(led_sink_en & rx_standby);
		if (rx_standby && !int_oe) run_cyc <= 0;
		else if (!int_oe) run_cyc <= run_cyc + 1;
		if (als_sampling && samp_cyc == 0) begin
			seed = lfsr(seed);
			als_adc_data <= #1 seed;
			sum <= sum + int'(seed);
			nconv <= nconv + 1;
		end
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wait_irq(input int lim);
		for (int i = 0; i < lim && int_oe !== 1'b1; i++) @(posedge clk_sys);
		#1;
		chk(int_oe, 1'b1);
	endtask
	// one ambient measurement; standard or back-to-back conversions
	task automatic meas(input logic c, input logic [2:0] n);
		logic [15:0] res;
		int          exp;
		host_u.wr(REG_ALS_CFG, {24'h0, c, 4'h0, n}, 1);
		sum = 0;
		nconv = 0;
		host_u.wr(REG_CMD, 32'h10, 1);
		wait_irq(FRAME + 100);
		res = 16'(sum >> n);
		exp = c ? (CONV << n) : FRAME;
		chk(16'(nconv), 16'(1 << n));
		chk(16'(run_cyc >= exp - 3 && run_cyc <= exp + 3), 16'h1);
		host_u.rd(REG_ALS_HI, c, 2, v);
		chk(v, res);
		host_u.rd(REG_IRQ_STAT, 1'b0, 1, v);
		chk(v, als_stat(res));
		chk(rx_standby, 1'b1);
		host_u.wr(REG_IRQ_STAT, 32'h0F, 1);
	endtask
	task automatic conclude();
		if (failures == 0 && num_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		repeat (90000) @(posedge clk_sys);
		failures++;
		conclude();
	end
	initial begin
		repeat (5) @(posedge clk_sys);
		#1 rst_b = 1'b1;
		host_u.gap(10);
		host_u.rd(REG_MOD_TIME, 1'b0, 2, v);
		chk(v, {MOD_TIME_RST, 8'h00});
		chk(mod_timing, 16'h0001);
		host_u.wr(REG_AMB_IR, 32'hFF, 1); // reserved place ignores writes
		host_u.rd(REG_AMB_IR, 1'b1, 1, v);
		chk(v, 16'h0000);
		for (int i = 0; i < 2; i++) begin
			seed = lfsr(seed);
			host_u.wr(REG_MOD_TIME, {24'h0, seed[7:0]}, 1);
			host_u.rd(REG_MOD_TIME, i[0], 1, v);
			chk(v, {8'h00, seed[7:0]});
			chk(mod_timing, seed[7:0]);
		end
		host_u.wr(REG_MOD_TIME, 32'h1, 1); // recommended setting
		chk(mod_timing, 16'(MOD_TIME_RST));
		host_u.wr(REG_TLO_HI, 32'hFFFF0000, 4); // limits force both flags
		for (int i = 0; i < 2; i++) begin
			seed = lfsr(seed);
			bio_adc_data = seed;
			host_u.wr(REG_LED, {24'h0, seed[15:8]}, 1);
			chk(led_current, seed[15:8]);
			chk({rx_standby, led_sink_en}, 16'h2);
			sink_cyc = 0;
			host_u.wr(REG_CMD, 32'h08, 1);
			wait_irq(300);
			chk(16'(sink_cyc), 16'(CONV));
			host_u.rd(REG_IRQ_STAT, i[0], 1, v);
			chk(v, 16'h0008);
			host_u.rd(REG_BIO_HI, 1'b1, 2, v);
			chk(v, seed);
			host_u.wr(REG_IRQ_STAT, 32'h07, 1); // zeros keep the flag
			host_u.rd(REG_IRQ_STAT, 1'b0, 1, v);
			chk(v, 16'h0008);
			host_u.wr(REG_IRQ_STAT, 32'h08, 1);
			host_u.rd(REG_IRQ_STAT, 1'b1, 1, v);
			chk({v[14:0], int_oe}, 16'h0000);
		end
		meas(1'b0, 3'h1);
		meas(1'b0, 3'h7);
		meas(1'b1, 3'h0);
		meas(1'b1, 3'h7);
		chk(16'(bad_sink), 16'h0000);
		chk(host_u.nak_seen, 1'b0);
		chk({sda_o, int_o}, 16'h0000);
		conclude();
	end
endmodule // tb_optical_sensor_irq_and_readout
`default_nettype wire
